/* File: design/dopi_pkg.sv */
// constants for the digital output process image mapper
package dopi_pkg;
    // module variants
    typedef enum logic [2:0] {
        DOPI_K_1CH_STAT,
        DOPI_K_2CH,
        DOPI_K_2CH_DIAG1,
        DOPI_K_2CH_DIAG2,
        DOPI_K_4CH,
        DOPI_K_4CH_DIAG1
    } dopi_kind_t;

    // two-bit diagnostic codes
    localparam logic [1:0] DOPI_DIAG_OK    = 2'h0;
    localparam logic [1:0] DOPI_DIAG_OPEN  = 2'h1;
    localparam logic [1:0] DOPI_DIAG_SHORT = 2'h2;

    // byte address offsets
    localparam logic [7:0] DOPI_OFF_CFG    = 8'h00;
    localparam logic [7:0] DOPI_OFF_OUT    = 8'h04;
    localparam logic [7:0] DOPI_OFF_IN     = 8'h08;
    localparam logic [7:0] DOPI_OFF_INFO   = 8'h0C;

    // reset values
    localparam logic [2:0] DOPI_CFG_RST    = 3'h3;
    localparam logic [7:0] DOPI_OUT_RST    = 8'h00;
    localparam logic [7:0] DOPI_ANA_RST    = 8'h00;

    // object class codes
    localparam logic [7:0] DOPI_CLASS_DI   = 8'h65;
    localparam logic [7:0] DOPI_CLASS_DO   = 8'h66;

    // bits per subindex
    localparam int         DOPI_SUB_BITS   = 8;
endpackage

/* File: design/dopi_sync.sv */
// two-flop synchroniser bank for field inputs
`timescale 1ns/10ps
module dopi_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            q_o  <= s1_r;
        end
    end
endmodule

/* File: design/dopi_top.sv */
// digital output process image mapper with ahb-lite register access
// Behaviour
// - one image bit alone drives each channel
// - per-channel fault flag in input image
// - digital bytes follow analog output data
// - one subindex per eight packed bits
// - one output object instance per channel, except two for single channel, four for two-bit codes
// - single channel: ctrl bit0, manual status bit0
// - single channel module takes two instances
// - two channel: bits 0,1 drive channels
// - one-bit flags of two channels at bits 0,1
// - two-bit codes at bits 1:0 and 3:2
// - code 00 normal, others fault kinds
// - four diag bits, out bits 2,3 unused
// - two-bit module takes four input instances
// - four channel: bits 0..3, four instances
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module dopi_top (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // field side
    input  wire logic [3:0]  FAULT_I,
    input  wire logic [3:0]  FAULT_HI_I,
    input  wire logic        MANUAL_I,
    output logic      [3:0]  CH_OUT_O
);
    logic [2:0]  cfg_r;
    logic [7:0]  out_img_r;
    logic [7:0]  ana_len_r;
    logic [7:0]  in_img;
    logic [7:0]  eff_out;
    logic [3:0]  fault_s;
    logic [3:0]  fault_hi_s;
    logic        manual_s;
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic        sel_ok;
    dopi_pkg::dopi_kind_t kind;

    assign kind = dopi_pkg::dopi_kind_t'(cfg_r);

    // field inputs cross into the clock domain first
    dopi_sync #(.W(9)) u_sync (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   ({MANUAL_I, FAULT_HI_I, FAULT_I}),
        .q_o   ({manual_s, fault_hi_s, fault_s})
    );

    // bit mask of the output channels of a variant
    function automatic logic [7:0] ch_mask(dopi_pkg::dopi_kind_t k);
        case (k)
            dopi_pkg::DOPI_K_1CH_STAT:  ch_mask = 8'h01;
            dopi_pkg::DOPI_K_2CH:       ch_mask = 8'h03;
            dopi_pkg::DOPI_K_2CH_DIAG1: ch_mask = 8'h03;
            dopi_pkg::DOPI_K_2CH_DIAG2: ch_mask = 8'h03;
            dopi_pkg::DOPI_K_4CH:       ch_mask = 8'h0F;
            dopi_pkg::DOPI_K_4CH_DIAG1: ch_mask = 8'h0F;
            default:                    ch_mask = 8'h00;
        endcase
    endfunction

    // object instances taken per class
    function automatic logic [7:0] do_inst(dopi_pkg::dopi_kind_t k);
        case (k)
            dopi_pkg::DOPI_K_1CH_STAT:  do_inst = 8'h02;
            dopi_pkg::DOPI_K_2CH_DIAG2: do_inst = 8'h04;
            dopi_pkg::DOPI_K_4CH:       do_inst = 8'h04;
            dopi_pkg::DOPI_K_4CH_DIAG1: do_inst = 8'h04;
            default:                    do_inst = 8'h02;
        endcase
    endfunction

    function automatic logic [7:0] di_inst(dopi_pkg::dopi_kind_t k);
        case (k)
            dopi_pkg::DOPI_K_2CH_DIAG1: di_inst = 8'h02;
            dopi_pkg::DOPI_K_2CH_DIAG2: di_inst = 8'h04;
            dopi_pkg::DOPI_K_4CH_DIAG1: di_inst = 8'h04;
            default:                    di_inst = 8'h00;
        endcase
    endfunction

    // channel drive comes only from the masked control bits
    assign eff_out = out_img_r & ch_mask(kind);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CH_OUT_O <= 4'h0;
        end else begin
            CH_OUT_O <= eff_out[3:0];
        end
    end

    // input image per variant, unused bits zero
    always_comb begin
        in_img = 8'h00;
        case (kind)
            dopi_pkg::DOPI_K_1CH_STAT:
                in_img[0] = manual_s;
            dopi_pkg::DOPI_K_2CH_DIAG1:
                in_img[1:0] = fault_s[1:0];
            dopi_pkg::DOPI_K_2CH_DIAG2: begin
                // open/short-high code 01, short-low/overload 10
                in_img[1:0] = fault_s[0] ? dopi_pkg::DOPI_DIAG_OPEN :
                              fault_hi_s[0] ? dopi_pkg::DOPI_DIAG_SHORT :
                              dopi_pkg::DOPI_DIAG_OK;
                in_img[3:2] = fault_s[1] ? dopi_pkg::DOPI_DIAG_OPEN :
                              fault_hi_s[1] ? dopi_pkg::DOPI_DIAG_SHORT :
                              dopi_pkg::DOPI_DIAG_OK;
            end
            dopi_pkg::DOPI_K_4CH_DIAG1:
                in_img[3:0] = fault_s;
            default:
                in_img = 8'h00;
        endcase
    end

    // ahb-lite: zero wait, always okay
    assign sel_ok = HSEL_I && HREADY_I && HTRANS_I[1];
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= sel_ok && HWRITE_I;
            rd_pend_r <= sel_ok && !HWRITE_I;
            if (sel_ok) begin
                addr_r <= HADDR_I[7:0];
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg_r     <= dopi_pkg::DOPI_CFG_RST;
            out_img_r <= dopi_pkg::DOPI_OUT_RST;
            ana_len_r <= dopi_pkg::DOPI_ANA_RST;
        end else if (wr_pend_r) begin
            case (addr_r)
                dopi_pkg::DOPI_OFF_CFG: begin
                    cfg_r     <= HWDATA_I[2:0];
                    ana_len_r <= HWDATA_I[15:8];
                end
                dopi_pkg::DOPI_OFF_OUT:
                    out_img_r <= HWDATA_I[7:0];
                default: ;
            endcase
        end
    end

    // read data registered at the end of the address phase
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (sel_ok && !HWRITE_I) begin
            case (HADDR_I[7:0])
                dopi_pkg::DOPI_OFF_CFG:
                    HRDATA_O <= {16'h0000, ana_len_r, 5'h00, cfg_r};
                dopi_pkg::DOPI_OFF_OUT:
                    HRDATA_O <= {24'h000000, out_img_r};
                dopi_pkg::DOPI_OFF_IN:
                    HRDATA_O <= {24'h000000, in_img};
                dopi_pkg::DOPI_OFF_INFO:
                    // digital byte sits after analog bytes, one subindex
                    HRDATA_O <= {ana_len_r, 8'h01,
                                 do_inst(kind), di_inst(kind)};
                default:
                    HRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    always_comb begin
        // rd_pend_r is not read by any logic or check
    end

    out_follow_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CH_OUT_O == $past(out_img_r[3:0] & ch_mask(kind)[3:0]))
        else $error("channel drive does not follow control bits");
    unused_out_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_2CH_DIAG2) |=> CH_OUT_O[3:2] == 2'h0)
        else $error("unused output bits drive a channel");
    single_ch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_1CH_STAT)
            |-> in_img == {7'h00, manual_s})
        else $error("manual status not mirrored");
    diag1_map_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_2CH_DIAG1)
            |-> in_img == {6'h00, fault_s[1:0]})
        else $error("one-bit diagnostic map wrong");
    diag2_ok_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_2CH_DIAG2 && !fault_s[1] && !fault_hi_s[1])
            |-> in_img[3:2] == dopi_pkg::DOPI_DIAG_OK)
        else $error("channel 2 code not normal");
    diag2_fault_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_2CH_DIAG2 && fault_s[0])
            |-> in_img[1:0] == dopi_pkg::DOPI_DIAG_OPEN)
        else $error("channel 1 code wrong");
    fault_flag_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_4CH_DIAG1 && $rose(fault_s[2]))
            |-> in_img[2])
        else $error("fault flag not set");
    in_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        in_img[7:4] == 4'h0)
        else $error("unused input bits not zero");
    inst_cnt_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_2CH_DIAG2)
            |-> di_inst(kind) == 8'h04 && do_inst(kind) == 8'h04)
        else $error("instance count wrong");
    four_inst_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (kind == dopi_pkg::DOPI_K_4CH) |-> do_inst(kind) == 8'h04)
        else $error("four channel instance count wrong");
endmodule

/* File: dv/dopi_ctrl_model.sv */
// bus master model of the controller reading and writing the images
`timescale 1ns/10ps
module dopi_ctrl_model (
    // bus clock
    input  wire logic        clk_i,
    // ahb-lite master
    input  wire logic [31:0] hrdata_i,
    input  wire logic        hready_i,
    output logic             hsel_o,
    output logic      [31:0] haddr_o,
    output logic      [1:0]  htrans_o,
    output logic             hwrite_o,
    output logic      [2:0]  hsize_o,
    output logic      [31:0] hwdata_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= 2'h2;
        hwrite_o <= w;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
        // stale data must not look valid after release
        hwdata_o <= ~d;
    endtask

    // a set flag alone does not name the fault: fetch the data bits too
    task automatic read_diag(output logic [31:0] q, output logic [31:0] dat);
        xfer(1'b0, dopi_pkg::DOPI_OFF_IN, 32'h0, q);
        dat = 32'h0;
        if (q[7:0] != 8'h00) xfer(1'b0, dopi_pkg::DOPI_OFF_OUT, 32'h0, dat);
    endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the process image mapper
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hready, hresp, man;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  flt, fhi, ch;
    logic [31:0] haddr, hwdata, hrdata, q, dat;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [3:0]  msk [6] = '{4'h1, 4'h3, 4'h3, 4'h3, 4'hF, 4'hF};
    logic [7:0]  nout [6] = '{8'h02, 8'h02, 8'h02, 8'h04, 8'h04, 8'h04};

    dopi_top uut (
        .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .FAULT_I(flt),
        .FAULT_HI_I(fhi), .MANUAL_I(man), .CH_OUT_O(ch));
    dopi_ctrl_model ctrl (
        .clk_i(clk), .hrdata_i(hrdata), .hready_i(hready), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));

    always #2.5 clk = ~clk;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ctrl.xfer(1'b1, a, d, dat);
    endtask

    task automatic rd(input logic [7:0] a);
        ctrl.xfer(1'b0, a, 32'h0, q);
    endtask

    function automatic logic [7:0] exp_in(int k, logic [3:0] f, h, logic m);
        logic [1:0] c [2];
        for (int i = 0; i < 2; i++)
            c[i] = f[i] ? dopi_pkg::DOPI_DIAG_OPEN :
                   h[i] ? dopi_pkg::DOPI_DIAG_SHORT : dopi_pkg::DOPI_DIAG_OK;
        case (k)
            0: return {7'h0, m};
            2: return {6'h0, f[1:0]};
            3: return {4'h0, c[1], c[0]};
            5: return {4'h0, f};
            default: return 8'h00;
        endcase
    endfunction

    task automatic t_reset();
        chk("channels", 32'h0, {28'h0, ch});
        chk("resp", 32'h0, {31'h0, hresp});
        rd(dopi_pkg::DOPI_OFF_CFG);
        chk("cfg", {29'h0, dopi_pkg::DOPI_CFG_RST}, {29'h0, q[2:0]});
    endtask

    task automatic t_out();
        logic [7:0] p;
        for (int k = 0; k < 6; k++) begin
            wr(dopi_pkg::DOPI_OFF_CFG, 32'(k));
            for (int j = 0; j < 2; j++) begin
                p = j ? 8'hFA : 8'hF5;
                wr(dopi_pkg::DOPI_OFF_OUT, {24'hFFFFFF, p});
                @(posedge clk);
                #1 chk("channels", {28'h0, p[3:0] & msk[k]}, {28'h0, ch});
                rd(dopi_pkg::DOPI_OFF_OUT);
                chk("out image", {24'h0, p}, q);
            end
        end
    endtask

    task automatic t_info();
        for (int k = 0; k < 6; k++) begin
            wr(dopi_pkg::DOPI_OFF_CFG, {16'h0, 8'(k * 51), 5'h0, 3'(k)});
            rd(dopi_pkg::DOPI_OFF_INFO);
            chk("info", {16'h0, 8'(k * 51), 8'h01}, {16'h0, q[31:16]});
            chk("out count", {24'h0, nout[k]}, {24'h0, q[15:8]});
            if (k == 3) chk("in count", 32'h4, {24'h0, q[7:0]});
        end
    endtask

    task automatic t_diag();
        logic [3:0] fs [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
        logic [3:0] hs [4] = '{4'h0, 4'hA, 4'hF, 4'h0};
        logic [7:0] e;
        for (int k = 0; k < 6; k++) begin
            wr(dopi_pkg::DOPI_OFF_CFG, 32'(k));
            wr(dopi_pkg::DOPI_OFF_OUT, 32'h3);
            for (int j = 0; j < 4; j++) begin
                @(posedge clk);
                flt <= fs[j];
                fhi <= hs[j];
                man <= j[0];
                repeat (3) @(posedge clk);
                e = exp_in(k, fs[j], hs[j], j[0]);
                ctrl.read_diag(q, dat);
                chk("in image", {24'h0, e}, q);
                chk("data bits", (e != 8'h00) ? 32'h3 : 32'h0, dat);
            end
        end
    endtask

    task automatic t_unmap();
        rd(8'h10);
        chk("unmapped", 32'h0, q);
        wr(8'h10, 32'hFF);
        wr(dopi_pkg::DOPI_OFF_IN, 32'hFF);
        @(posedge clk);
        #1 chk("channels", 32'h3, {28'h0, ch});
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        flt = 4'h0;
        fhi = 4'h0;
        man = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_out();
        t_info();
        t_diag();
        t_unmap();
        print_verdict();
    end
endmodule
